/* File: rtl/fccr_pkg.sv */
// Constants, field layouts and decode helpers for the front-end channel control registers.
// Assumes a 16-bit register port with word offsets; used by the register and bank design files of the block.
package fccr_pkg;

   localparam int DATA_W = 16;
   localparam int NUM_CH = 8;
   localparam int NUM_REGS = 6;

   localparam logic [15:0] RESET_VALUE = 16'h0000;

   // Register order in the bank: power, doppler, phase 1-4, phase 5-8, gain, filter.
   localparam logic [7:0] OFS_POWER = 8'h35;
   localparam logic [7:0] OFS_DOPPLER = 8'h36;
   localparam logic [7:0] OFS_PHASE_LO = 8'h37;
   localparam logic [7:0] OFS_PHASE_HI = 8'h38;
   localparam logic [7:0] OFS_GAIN = 8'h39;
   localparam logic [7:0] OFS_FILTER = 8'h3b;

   // Writable bits; reserved bits are not stored and read back as zero.
   localparam logic [15:0] MASK_POWER = 16'hfcff;
   localparam logic [15:0] MASK_DOPPLER = 16'h0f7f;
   localparam logic [15:0] MASK_FULL = 16'hffff;
   localparam logic [15:0] MASK_FILTER = 16'h03fc;

   localparam logic [7:0] REG_OFS [NUM_REGS] = '{OFS_POWER, OFS_DOPPLER, OFS_PHASE_LO,
      OFS_PHASE_HI, OFS_GAIN, OFS_FILTER};
   localparam logic [15:0] REG_MASK [NUM_REGS] = '{MASK_POWER, MASK_DOPPLER, MASK_FULL,
      MASK_FULL, MASK_FULL, MASK_FILTER};

   localparam int POS_CH_PD = 0;
   localparam int POS_PWR_MODE = 10;
   localparam int POS_ATT_OFF = 12;
   localparam int POS_FRONT_OFF = 13;
   localparam int POS_FAST_WAKE = 14;
   localparam int POS_DEEP = 15;

   localparam int POS_SUM_FB = 0;
   localparam int POS_FAST_CLK = 5;
   localparam int POS_BASE_CLK = 6;
   localparam int POS_PATH_SEL = 8;
   localparam int POS_SUM_DIS_N = 9;
   localparam int POS_CLK_MULT = 10;

   localparam int POS_HPF = 2;
   localparam int POS_ATT_STEPS = 4;
   localparam int POS_ATT_EN = 7;
   localparam int POS_SUM_TEST_N = 8;
   localparam int POS_GA_TEST = 9;

   localparam logic [5:0] ATT_STEP_DB = 6'h06;

   typedef enum logic [1:0] {PWR_LOW_POWER, PWR_LOW_NOISE, PWR_MEDIUM, PWR_RESERVED}
      fccr_power_mode_t;
   typedef enum logic [1:0] {MULT_16X, MULT_8X, MULT_4X, MULT_1X} fccr_clk_mult_t;
   typedef enum logic [1:0] {GAIN_18DB, GAIN_24DB, GAIN_12DB, GAIN_RESERVED} fccr_gain_t;

   function automatic logic [4:0] clk_ratio(input logic [1:0] code);
      logic [4:0] r;
      r = 5'h10;
      case (fccr_clk_mult_t'(code))
         MULT_16X: r = 5'h10;
         MULT_8X: r = 5'h08;
         MULT_4X: r = 5'h04;
         default: r = 5'h01;
      endcase
      return r;
   endfunction

   function automatic logic [5:0] atten_db(input logic [2:0] steps, input logic en);
      return en ? 6'({3'h0, steps} * ATT_STEP_DB) : 6'h00;
   endfunction

endpackage

/* File: rtl/fccr_reg16.sv */
// One 16-bit control register with a mask of writable bits.
// Assumes a one-cycle write enable from the bank's address decode.
`timescale 1ns/1ps
`default_nettype none
module fccr_reg16 #(
   parameter logic [15:0] MASK = 16'hffff
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   output var logic [15:0] q
);
   logic [15:0] q_d;

   // Unwritable bits are forced to zero so that reserved bits can never hold a one.
   assign q_d = wr_en ? (wdata & MASK) : q;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q <= fccr_pkg::RESET_VALUE;
      end else begin
         q <= q_d;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/fccr_chan_ctrl.sv */
// Per-channel power and gain decode for one receive channel.
// Assumes all inputs come straight from register flops, so outputs settle within the cycle.
`timescale 1ns/1ps
`default_nettype none
module fccr_chan_ctrl (
   input wire logic ch_off,
   input wire logic doppler_sel,
   input wire logic atten_off,
   input wire logic front_off,
   input wire logic fast_wake,
   input wire logic deep,
   input wire logic indiv_en,
   input wire logic [1:0] ch_gain,
   input wire logic [1:0] glob_gain,
   output logic lna_on,
   output logic atten_on,
   output logic mixer_on,
   output logic [1:0] gain
);
   logic vca_sleep;

   // Either sleep level stops the amplifier chain; deep sleep dominates at the top level.
   assign vca_sleep = fast_wake | deep;

   // The amplifier runs on both paths, so a channel power-down always stops it.
   assign lna_on = !ch_off && !front_off && !vca_sleep;

   // Attenuator and gain stage keep running on the Doppler path unless switched off.
   assign atten_on = !ch_off && !atten_off && !vca_sleep;

   assign mixer_on = doppler_sel && !ch_off;

   assign gain = indiv_en ? ch_gain : glob_gain;
endmodule
`default_nettype wire

/* File: rtl/fccr_regs.sv */
// Control register bank for the eight-channel receive front end, with control decode.
// Assumes a plain register port: one-cycle strobes, read data valid only the cycle after.
`timescale 1ns/1ps
`default_nettype none
module fccr_regs #(
   parameter int ADDR_W = 8,
   parameter int NUM_CH = fccr_pkg::NUM_CH
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic per_channel_gain_enable,
   input wire logic [1:0] global_gain_code,
   input wire logic imaging_test_mode,
   output logic [NUM_CH-1:0] lna_on,
   output logic [NUM_CH-1:0] atten_gainamp_on,
   output logic [NUM_CH-1:0] mixer_on,
   output logic [2*NUM_CH-1:0] channel_gain_code,
   output logic [4*NUM_CH-1:0] mixer_phase_code,
   output logic [1:0] power_noise_tradeoff,
   output logic fast_wake_sleep,
   output logic deep_sleep,
   output logic doppler_path_on,
   output logic [4:0] summer_feedback_select,
   output logic fast_doppler_clock_cmos,
   output logic base_doppler_clock_diff,
   output logic [4:0] doppler_clock_ratio,
   output logic summer_on,
   output logic [1:0] input_highpass_corner,
   output logic [5:0] digital_atten_db,
   output logic gainamp_to_doppler_out
);

   // Field packing is fixed at eight channels, and offsets need at least six address bits.
   if (NUM_CH != 8) begin : g_bad_ch
      $error("fccr_regs supports exactly eight channels");
   end
   if (ADDR_W < 6) begin : g_bad_addr
      $error("fccr_regs needs an address of at least six bits");
   end

   logic [15:0] reg_q [fccr_pkg::NUM_REGS];
   logic [fccr_pkg::NUM_REGS-1:0] hit;
   logic [15:0] rd_sel;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic [15:0] pwr;
   logic [15:0] dop;
   logic [15:0] gsel;
   logic [15:0] filt;

   // Address match against each printed offset; upper address bits must be zero.
   for (genvar i = 0; i < fccr_pkg::NUM_REGS; i++) begin : g_reg
      assign hit[i] = (reg_addr == ADDR_W'(fccr_pkg::REG_OFS[i]));

      fccr_reg16 #(
         .MASK(fccr_pkg::REG_MASK[i])
      ) u_reg (
         .clock(clock),
         .rst_b(rst_b),
         .wr_en(reg_write && hit[i]),
         .wdata(reg_wdata),
         .q(reg_q[i])
      );
   end

   assign pwr = reg_q[0];
   assign dop = reg_q[1];
   assign gsel = reg_q[4];
   assign filt = reg_q[5];

   // Unmapped addresses read as zero; writes to them are dropped.
   always_comb begin
      if (hit[0]) begin
         rd_sel = reg_q[0];
      end else if (hit[1]) begin
         rd_sel = reg_q[1];
      end else if (hit[2]) begin
         rd_sel = reg_q[2];
      end else if (hit[3]) begin
         rd_sel = reg_q[3];
      end else if (hit[4]) begin
         rd_sel = reg_q[4];
      end else if (hit[5]) begin
         rd_sel = reg_q[5];
      end else begin
         rd_sel = 16'h0000;
      end
   end

   // Read data is held at zero outside the answer cycle so stale values never linger.
   assign rdata_d = reg_read ? rd_sel : 16'h0000;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Global power and mode decode.
   assign power_noise_tradeoff = pwr[fccr_pkg::POS_PWR_MODE +: 2];
   assign deep_sleep = pwr[fccr_pkg::POS_DEEP];
   assign fast_wake_sleep = pwr[fccr_pkg::POS_FAST_WAKE] && !pwr[fccr_pkg::POS_DEEP];

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      fccr_chan_ctrl u_ch (
         .ch_off(pwr[fccr_pkg::POS_CH_PD + c]),
         .doppler_sel(doppler_path_on),
         .atten_off(pwr[fccr_pkg::POS_ATT_OFF]),
         .front_off(pwr[fccr_pkg::POS_FRONT_OFF]),
         .fast_wake(fast_wake_sleep),
         .deep(deep_sleep),
         .indiv_en(per_channel_gain_enable),
         .ch_gain(gsel[2*c +: 2]),
         .glob_gain(global_gain_code),
         .lna_on(lna_on[c]),
         .atten_on(atten_gainamp_on[c]),
         .mixer_on(mixer_on[c]),
         .gain(channel_gain_code[2*c +: 2])
      );
   end

   assign mixer_phase_code = {reg_q[3], reg_q[2]};

   // Doppler path configuration.
   assign summer_feedback_select = dop[fccr_pkg::POS_SUM_FB +: 5];
   assign fast_doppler_clock_cmos = dop[fccr_pkg::POS_FAST_CLK];
   assign base_doppler_clock_diff = dop[fccr_pkg::POS_BASE_CLK];
   assign doppler_path_on = dop[fccr_pkg::POS_PATH_SEL];
   assign doppler_clock_ratio = fccr_pkg::clk_ratio(dop[fccr_pkg::POS_CLK_MULT +: 2]);

   // The summer obeys its Doppler enable on that path, and its test power bit only in
   // the imaging test mode; otherwise it is off to save power on the imaging path.
   assign summer_on = doppler_path_on ? !dop[fccr_pkg::POS_SUM_DIS_N]
      : (imaging_test_mode && filt[fccr_pkg::POS_SUM_TEST_N]);

   // Filter, attenuation and test routing.
   assign input_highpass_corner = filt[fccr_pkg::POS_HPF +: 2];
   assign digital_atten_db = fccr_pkg::atten_db(filt[fccr_pkg::POS_ATT_STEPS +: 3],
      filt[fccr_pkg::POS_ATT_EN]);
   assign gainamp_to_doppler_out = filt[fccr_pkg::POS_GA_TEST];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   logic wr_pwr;
   logic wr_dop;
   logic wr_filt;
   logic any_hit;
   assign wr_pwr = reg_write && hit[0];
   assign wr_dop = reg_write && hit[1];
   assign wr_filt = reg_write && hit[5];
   assign any_hit = |hit;

   chk_chan_pd_off: assert property (
      wr_pwr && reg_wdata[0] |=> !lna_on[0] && !atten_gainamp_on[0] && !mixer_on[0])
      else $error("channel one still active after power-down write");

   chk_read_phase: assert property (
      reg_read && hit[2] |=> reg_rdata == $past(reg_q[2]))
      else $error("phase register read returned wrong data");

   chk_write_readback: assert property (
      wr_pwr ##1 (reg_read && hit[0])
      |=> reg_rdata == ($past(reg_wdata, 2) & fccr_pkg::MASK_POWER))
      else $error("power register readback differs from masked write");

   chk_rdata_idle: assert property (
      !$past(reg_read) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside answer cycle");

   chk_power_mode: assert property (
      wr_pwr |=> power_noise_tradeoff == $past(reg_wdata[11:10]))
      else $error("power mode did not follow write");

   chk_deep_wins: assert property (
      deep_sleep |-> !fast_wake_sleep && lna_on == '0 && atten_gainamp_on == '0)
      else $error("deep sleep did not dominate");

   chk_atten_all_off: assert property (
      pwr[fccr_pkg::POS_ATT_OFF] |-> atten_gainamp_on == '0)
      else $error("attenuator running while switched off");

   chk_front_only: assert property (
      wr_pwr && reg_wdata == 16'h2000
      |=> lna_on == '0 && atten_gainamp_on == '1 [*2])
      else $error("front amplifier off affected other stages");

   chk_summer_ctl: assert property (
      (doppler_path_on && !dop[9] |-> summer_on) and
      (!doppler_path_on && !imaging_test_mode |-> !summer_on))
      else $error("summer enable decode wrong");

   chk_clk_ratio: assert property (
      wr_dop && reg_wdata[11:10] == 2'h3 |=> doppler_clock_ratio == 5'h01)
      else $error("1X clock multiple not selected");

   chk_clk_types: assert property (
      wr_dop |=> fast_doppler_clock_cmos == $past(reg_wdata[5])
         && base_doppler_clock_diff == $past(reg_wdata[6])
         && doppler_path_on == $past(reg_wdata[8]))
      else $error("Doppler clock or path select did not follow write");

   chk_atten_db: assert property (
      wr_filt |=> digital_atten_db ==
         ($past(reg_wdata[7]) ? 6'($past(reg_wdata[6:4]) * 6) : 6'h00))
      else $error("digital attenuation amount wrong");

   chk_gain_select: assert property (
      !per_channel_gain_enable |-> channel_gain_code == {NUM_CH{global_gain_code}})
      else $error("per-channel gain used while disabled");

   chk_test_route: assert property (
      wr_filt |=> gainamp_to_doppler_out == $past(reg_wdata[9])
         && input_highpass_corner == $past(reg_wdata[3:2]))
      else $error("filter register fields did not follow write");

   chk_sum_feedback: assert property (
      wr_dop |=> summer_feedback_select == $past(reg_wdata[4:0]))
      else $error("summing feedback select did not follow write");

   chk_phase_lo: assert property (
      reg_write && hit[2] |=> mixer_phase_code[15:0] == $past(reg_wdata))
      else $error("phase code of channels one to four did not follow write");

   chk_phase_hi: assert property (
      reg_write && hit[3] |=> mixer_phase_code[31:16] == $past(reg_wdata))
      else $error("phase code of channels five to eight did not follow write");

   chk_gain_per_ch: assert property (
      reg_write && hit[4] ##1 per_channel_gain_enable
      |-> channel_gain_code == $past(reg_wdata))
      else $error("per-channel gain codes not used while enabled");

   chk_ch8_pd_off: assert property (
      wr_pwr && reg_wdata[7] |=> !lna_on[7] && !atten_gainamp_on[7] && !mixer_on[7])
      else $error("channel eight still active after power-down write");

   chk_lna_alive: assert property (
      pwr[15:13] == 3'h0 && !pwr[0] |-> lna_on[0])
      else $error("front amplifier off without a power-down bit");

   chk_att_gainamp_only: assert property (
      wr_pwr && reg_wdata == 16'h1000
      |=> lna_on == '1 && atten_gainamp_on == '0)
      else $error("attenuator off bit affected the front amplifiers");

   chk_fast_wake: assert property (
      fast_wake_sleep |-> lna_on == '0 && atten_gainamp_on == '0)
      else $error("fast-wake sleep left the amplifier chain running");

   chk_deep_over_fast: assert property (
      wr_pwr && reg_wdata[15:14] == 2'h3 |=> deep_sleep && !fast_wake_sleep)
      else $error("deep sleep did not override fast-wake sleep");

   chk_mixer_path: assert property (
      !doppler_path_on |-> mixer_on == '0)
      else $error("mixer running on the imaging path");

   chk_ratio_16x: assert property (
      dop[fccr_pkg::POS_CLK_MULT +: 2] == 2'h0 |-> doppler_clock_ratio == 5'h10)
      else $error("16X clock multiple not selected");

   chk_sum_disabled: assert property (
      doppler_path_on && dop[fccr_pkg::POS_SUM_DIS_N] |-> !summer_on)
      else $error("summing amplifier running while disabled");

   chk_summer_test: assert property (
      !doppler_path_on && imaging_test_mode
      |-> summer_on == filt[fccr_pkg::POS_SUM_TEST_N])
      else $error("test summer power bit not obeyed in imaging test mode");

   chk_atten_disabled: assert property (
      !filt[fccr_pkg::POS_ATT_EN] |-> digital_atten_db == 6'h00)
      else $error("digital attenuation applied while disabled");

   chk_unmapped_read: assert property (
      reg_read && !any_hit |=> reg_rdata == 16'h0000)
      else $error("unmapped address read back nonzero data");

   chk_unmapped_write: assert property (
      reg_write && !any_hit |=> $stable(pwr) && $stable(dop) && $stable(gsel)
         && $stable(filt) && $stable(mixer_phase_code))
      else $error("write to an unmapped address changed a register");

   chk_reserved_power: assert property (
      reg_read && hit[0] |=> (reg_rdata & 16'h0300) == 16'h0000)
      else $error("reserved power register bits read back as one");

   chk_reserved_dop: assert property (
      reg_read && hit[1] |=> (reg_rdata & 16'hf080) == 16'h0000)
      else $error("reserved Doppler register bits read back as one");

   chk_reserved_filt: assert property (
      reg_read && hit[5] |=> (reg_rdata & 16'hfc03) == 16'h0000)
      else $error("reserved filter register bits read back as one");

   chk_no_write_hold: assert property (
      !reg_write |=> $stable(power_noise_tradeoff) && $stable(doppler_path_on)
         && $stable(mixer_phase_code) && $stable(input_highpass_corner))
      else $error("control output changed without a register write");

   // No write can land before the first edge after release, so all fields must be zero.
   chk_reset_zero: assert property (
      $rose(rst_b) |-> pwr == 16'h0000 && dop == 16'h0000 && gsel == 16'h0000
         && filt == 16'h0000 && mixer_phase_code == 32'h0000_0000)
      else $error("register not zero after reset");

   cov_doppler_summer: cover property (doppler_path_on && summer_on && mixer_on != '0);

   cov_deep_sleep: cover property (wr_pwr ##1 deep_sleep);

   cov_write_then_read: cover property (wr_filt ##1 (reg_read && hit[5]));

   cov_per_channel_gain: cover property (per_channel_gain_enable && gsel != 16'h0000);

   cov_unmapped_read: cover property (reg_read && !any_hit);

endmodule
`default_nettype wire

/* File: verif/test_fccr_regs.sv */
// Self-checking bench for the front-end channel control register bank.
// Assumes the plain register port with one-cycle strobes and combinational control decode.
`timescale 1ns/1ps
`default_nettype none
module test_fccr_regs;
   logic clock;
   logic rst_b;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [15:0] reg_rdata;
   logic per_channel_gain_enable;
   logic [1:0] global_gain_code;
   logic imaging_test_mode;
   logic [7:0] lna_on;
   logic [7:0] atten_gainamp_on;
   logic [7:0] mixer_on;
   logic [15:0] channel_gain_code;
   logic [31:0] mixer_phase_code;
   logic [1:0] power_noise_tradeoff;
   logic fast_wake_sleep;
   logic deep_sleep;
   logic doppler_path_on;
   logic [4:0] summer_feedback_select;
   logic fast_doppler_clock_cmos;
   logic base_doppler_clock_diff;
   logic [4:0] doppler_clock_ratio;
   logic summer_on;
   logic [1:0] input_highpass_corner;
   logic [5:0] digital_atten_db;
   logic gainamp_to_doppler_out;
   int n_errors;
   int tests_run;
   int seed;
   logic [15:0] m [6];

   fccr_regs u_fccr_regs (
      .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .per_channel_gain_enable(per_channel_gain_enable),
      .global_gain_code(global_gain_code), .imaging_test_mode(imaging_test_mode),
      .lna_on(lna_on), .atten_gainamp_on(atten_gainamp_on), .mixer_on(mixer_on),
      .channel_gain_code(channel_gain_code), .mixer_phase_code(mixer_phase_code),
      .power_noise_tradeoff(power_noise_tradeoff), .fast_wake_sleep(fast_wake_sleep),
      .deep_sleep(deep_sleep), .doppler_path_on(doppler_path_on),
      .summer_feedback_select(summer_feedback_select),
      .fast_doppler_clock_cmos(fast_doppler_clock_cmos),
      .base_doppler_clock_diff(base_doppler_clock_diff),
      .doppler_clock_ratio(doppler_clock_ratio), .summer_on(summer_on),
      .input_highpass_corner(input_highpass_corner), .digital_atten_db(digital_atten_db),
      .gainamp_to_doppler_out(gainamp_to_doppler_out)
   );

   always #2.5 clock = ~clock;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [15:0] mval(input logic [7:0] a);
      logic [15:0] v;
      v = 16'h0000;
      for (int k = 0; k < 6; k++) begin
         if (fccr_pkg::REG_OFS[k] == a) v = m[k];
      end
      return v;
   endfunction

   // Expected control outputs worked out from the model's register images.
   task automatic check_outputs();
      logic [15:0] p;
      logic [15:0] d;
      logic [15:0] f;
      logic [7:0] low_noise_amplifier;
      logic [7:0] att;
      logic [7:0] mix;
      logic [15:0] gain;
      int ratio;
      int db;
      p = m[0];
      d = m[1];
      f = m[5];
      for (int i = 0; i < 8; i++) begin
         low_noise_amplifier[i] = !(p[i] | p[13] | p[14] | p[15]);
         att[i] = !(p[i] | p[12] | p[14] | p[15]);
         mix[i] = d[8] & !p[i];
         gain[2*i +: 2] = per_channel_gain_enable ? m[4][2*i +: 2] : global_gain_code;
      end
      ratio = (d[11:10] == 2'h3) ? 1 : (16 >> d[11:10]);
      db = f[7] ? f[6:4] * 6 : 0;
      chk(32'(lna_on), 32'(low_noise_amplifier));
      chk(32'(atten_gainamp_on), 32'(att));
      chk(32'(mixer_on), 32'(mix));
      chk(32'(channel_gain_code), 32'(gain));
      chk(mixer_phase_code, {m[3], m[2]});
      chk(32'(power_noise_tradeoff), 32'(p[11:10]));
      chk(32'(fast_wake_sleep), 32'(p[14] & !p[15]));
      chk(32'(deep_sleep), 32'(p[15]));
      chk(32'(doppler_path_on), 32'(d[8]));
      chk(32'(summer_feedback_select), 32'(d[4:0]));
      chk(32'(fast_doppler_clock_cmos), 32'(d[5]));
      chk(32'(base_doppler_clock_diff), 32'(d[6]));
      chk(32'(doppler_clock_ratio), ratio);
      chk(32'(summer_on), 32'(d[8] ? !d[9] : (imaging_test_mode & f[8])));
      chk(32'(input_highpass_corner), 32'(f[3:2]));
      chk(32'(digital_atten_db), db);
      chk(32'(gainamp_to_doppler_out), 32'(f[9]));
   endtask

   // A write strobe stays up for one cycle; whoever drives next clears it.
   task automatic wr(input logic [7:0] a, input logic [15:0] dat);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_read <= 1'b0;
      reg_addr <= a;
      reg_wdata <= dat;
      per_channel_gain_enable <= 1'($random(seed));
      global_gain_code <= 2'($random(seed));
      imaging_test_mode <= 1'($random(seed));
      for (int k = 0; k < 6; k++) begin
         if (fccr_pkg::REG_OFS[k] == a) m[k] = dat & fccr_pkg::REG_MASK[k];
      end
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_write <= 1'b0;
      reg_addr <= a;
      #1;
      check_outputs();
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(32'(reg_rdata), 32'(mval(a)));
   endtask

   task automatic do_reset();
      @(posedge clock);
      rst_b <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         m[k] = 16'h0000;
      end
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
   endtask

   task automatic final_report();
      $display("Comparisons: %0d, mismatches: %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] a;
      seed = 32'hd7b4_d33c;
      clock = 1'b0;
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      per_channel_gain_enable = 1'b0;
      global_gain_code = 2'h0;
      imaging_test_mode = 1'b0;
      n_errors = 0;
      tests_run = 0;
      do_reset();
      // Two rounds, the second after a reset in mid-run, so stale state would show.
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 6; k++) begin
            rd(fccr_pkg::REG_OFS[k]);
         end
         // Single stage-off bits, so the per-stage power-down checks see their own cases.
         wr(fccr_pkg::OFS_POWER, 16'h2000);
         rd(fccr_pkg::OFS_POWER);
         wr(fccr_pkg::OFS_POWER, 16'h1000);
         rd(fccr_pkg::OFS_POWER);
         // Doppler path set up the way software is advised to: low noise mode first.
         wr(fccr_pkg::OFS_POWER, 16'h0400);
         rd(fccr_pkg::OFS_POWER);
         wr(fccr_pkg::OFS_DOPPLER, 16'h0100);
         rd(fccr_pkg::OFS_DOPPLER);
         chk(32'({power_noise_tradeoff, doppler_path_on}), 32'h0000_0003);
         // Offsets 0x35 to 0x3b include the hole at 0x3a; a few fully random addresses too.
         for (int n = 0; n < 150; n++) begin
            a = 8'h35 + 8'($unsigned($random(seed)) % 7);
            if ($unsigned($random(seed)) % 16 == 0) a = 8'($random(seed));
            wr(a, 16'($random(seed)));
            rd(a);
         end
         do_reset();
      end
      final_report();
   end

   // Each round needs well under 2000 cycles; this limit only catches a hang.
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      final_report();
   end
endmodule
`default_nettype wire
